// file: core/rpmc_pkg.sv
// Constants and types shared by the reset and power mode controller
package rpmc_pkg;

   // ********************************************************
   // Register map
   // ********************************************************
   localparam int unsigned ADR_W = 5;
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_SRC = 5'h04;
   localparam logic [4:0] ADDR_DIV = 5'h08;
   localparam logic [4:0] ADDR_STAT = 5'h0C;

   // ********************************************************
   // Control register fields
   // ********************************************************
   localparam int unsigned CTRL_W = 10;
   localparam int unsigned CTL_BO_EN = 0;
   localparam int unsigned CTL_BOIRQ = 1;
   localparam int unsigned CTL_SWRST = 2;
   localparam int unsigned CTL_MODE_LO = 3;
   localparam int unsigned CTL_PIN_EN = 5;
   localparam int unsigned CTL_RCSEL = 6;
   localparam int unsigned CTL_RTCEN = 7;
   localparam int unsigned CTL_CMPPD = 8;
   localparam int unsigned CTL_BRKEN = 9;
   localparam logic [9:0] CTRL_RST = 10'h021;
   localparam logic [9:0] CTRL_STORE_MASK = 10'h3E3;
   localparam logic [1:0] REQ_IDLE = 2'h1;
   localparam logic [1:0] REQ_PD = 2'h2;
   localparam logic [1:0] REQ_TPD = 2'h3;

   // ********************************************************
   // Reset source register fields
   // ********************************************************
   localparam int unsigned SRC_W = 6;
   localparam int unsigned SRC_EXT = 0;
   localparam int unsigned SRC_PWR_ON = 1;
   localparam int unsigned SRC_BROWN = 2;
   localparam int unsigned SRC_WDT = 3;
   localparam int unsigned SRC_SW = 4;
   localparam int unsigned SRC_BRK = 5;
   localparam logic [5:0] SRC_POR_VAL = 6'h06;

   // ********************************************************
   // Divider and timing
   // ********************************************************
   localparam int unsigned DIV_W = 8;
   localparam logic [3:0] BRK_BITS = 4'hB;
   localparam int unsigned RST_HOLD_DEF = 16;
   localparam int unsigned WAKE_RC_DEF = 64;
   localparam int unsigned WAKE_XTAL_DEF = 1024;

   // ********************************************************
   // Operating modes
   // ********************************************************
   typedef enum logic [2:0] {
      RPMC_RUN = 3'b000,
      RPMC_IDLE = 3'b001,
      RPMC_PD = 3'b010,
      RPMC_TPD = 3'b011,
      RPMC_WAKE = 3'b100
   } rpmc_mode_t;

endpackage

// file: core/rpmc_top.sv
// Reset gathering, reset source flags, clock divider and low-power mode control
`timescale 1ns/1ps
`default_nettype none

module rpmc_top #(
   parameter int unsigned RST_HOLD = rpmc_pkg::RST_HOLD_DEF,
   parameter int unsigned WAKE_RC = rpmc_pkg::WAKE_RC_DEF,
   parameter int unsigned WAKE_XTAL = rpmc_pkg::WAKE_XTAL_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [rpmc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic por_detect,
   input wire logic bo_level,
   input wire logic wdt_reset_req,
   input wire logic uart_rx,
   input wire logic uart_bit_tick,
   input wire logic rst_pin_in,
   input wire logic irq_pending,
   input wire logic wake_irq,
   output logic core_rst_n,
   output logic core_clk_en,
   output logic periph_clk_en,
   output logic osc_en,
   output logic rc_osc_en,
   output logic bod_power_en,
   output logic cmp_power_en,
   output logic bo_irq,
   output logic pin_gpio_in
);
   import rpmc_pkg::*;

   // ********************************************************
   // State
   // ********************************************************
   localparam int unsigned WK_W = 16;
   localparam logic [WK_W-1:0] WAKE_RC_CNT = WK_W'(WAKE_RC);
   localparam logic [WK_W-1:0] WAKE_XTAL_CNT = WK_W'(WAKE_XTAL);
   localparam logic [7:0] HOLD_CNT = 8'(RST_HOLD);

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [SRC_W-1:0] src;
      logic [DIV_W-1:0] div_set;
      logic [DIV_W-1:0] div_act;
      logic [8:0] div_cnt;
      logic core_tick;
      rpmc_mode_t mode;
      logic [WK_W-1:0] wake_cnt;
      logic [7:0] hold_cnt;
      logic powerup;
      logic [3:0] brk_cnt;
      logic brk_armed;
      logic ack;
      logic [31:0] rdat;
   } rpmc_state_t;

   rpmc_state_t s_ff;
   rpmc_state_t nxt_s;

   logic hit;
   logic wr;
   logic [31:0] bmask;
   logic [31:0] rd;
   logic pin_rst;
   logic bo_active;
   logic bo_rst;
   logic sw_rst;
   logic brk_rst;
   logic any_rst;
   logic [SRC_W-1:0] src_clr;
   logic [1:0] mode_req;

   // Core clock period minus one for a divider setting: 0 means divide by 1
   function automatic logic [8:0] rpmc_ratio_m1(input logic [DIV_W-1:0] n);
      logic [8:0] r;
      r = (n == 8'h00) ? 9'h000 : ({n, 1'b0} - 9'h001);
      return r;
   endfunction

   // Byte lane select to a bit mask
   function automatic logic [31:0] rpmc_bmask(input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return m;
   endfunction

   // ********************************************************
   // Next state
   // ********************************************************
   always_comb begin
      nxt_s = s_ff;
      hit = wb_cyc_i && wb_stb_i;
      wr = hit && wb_we_i && s_ff.ack;
      bmask = rpmc_bmask(wb_sel_i);
      rd = 32'h0000_0000;
      src_clr = 6'h00;
      mode_req = 2'h0;
      sw_rst = 1'b0;

      // Register read, latched so data stands with ack
      if (wb_adr_i == ADDR_CTRL) begin
         rd = {22'h00_0000, s_ff.ctrl};
      end else if (wb_adr_i == ADDR_SRC) begin
         rd = {26'h000_0000, s_ff.src};
      end else if (wb_adr_i == ADDR_DIV) begin
         rd = {24'h00_0000, s_ff.div_set};
      end else if (wb_adr_i == ADDR_STAT) begin
         rd = {27'h000_0000, s_ff.powerup, (s_ff.hold_cnt != 8'h00), s_ff.mode};
      end
      nxt_s.ack = hit && !s_ff.ack;
      if (hit && !s_ff.ack) begin
         nxt_s.rdat = rd;
      end

      // Register writes take effect at the acknowledging edge
      if (wr && wb_adr_i == ADDR_CTRL) begin
         nxt_s.ctrl = ((s_ff.ctrl & ~bmask[9:0]) | (wb_dat_i[9:0] & bmask[9:0])) & CTRL_STORE_MASK;
         sw_rst = wb_sel_i[0] && wb_dat_i[CTL_SWRST];
         mode_req = wb_sel_i[0] ? wb_dat_i[CTL_MODE_LO +: 2] : 2'h0;
      end else if (wr && wb_adr_i == ADDR_SRC) begin
         src_clr = bmask[5:0] & ~wb_dat_i[5:0];
      end else if (wr && wb_adr_i == ADDR_DIV && wb_sel_i[0]) begin
         nxt_s.div_set = wb_dat_i[7:0];
      end

      // Reset sources
      pin_rst = !rst_pin_in && (s_ff.ctrl[CTL_PIN_EN] || s_ff.powerup);
      bo_active = s_ff.ctrl[CTL_BO_EN] && bo_level && (s_ff.mode != RPMC_TPD);
      bo_rst = bo_active && !s_ff.ctrl[CTL_BOIRQ];
      brk_rst = s_ff.ctrl[CTL_BRKEN] && s_ff.brk_armed && uart_bit_tick && !uart_rx
         && (s_ff.brk_cnt == BRK_BITS - 4'h1);
      any_rst = por_detect || pin_rst || bo_rst || wdt_reset_req || sw_rst || brk_rst;

      // Break detector: count low bit samples, rearm once the line goes high
      if (uart_bit_tick) begin
         if (uart_rx) begin
            nxt_s.brk_cnt = 4'h0;
            nxt_s.brk_armed = 1'b1;
         end else if (brk_rst) begin
            nxt_s.brk_cnt = 4'h0;
            nxt_s.brk_armed = 1'b0;
         end else if (s_ff.brk_armed) begin
            nxt_s.brk_cnt = s_ff.brk_cnt + 4'h1;
         end
      end

      // Reset source flags: a set in the same cycle beats a clear
      nxt_s.src = s_ff.src & ~src_clr;
      if (pin_rst) nxt_s.src[SRC_EXT] = 1'b1;
      if (bo_active) nxt_s.src[SRC_BROWN] = 1'b1;
      if (wdt_reset_req) nxt_s.src[SRC_WDT] = 1'b1;
      if (sw_rst) nxt_s.src[SRC_SW] = 1'b1;
      if (brk_rst) nxt_s.src[SRC_BRK] = 1'b1;
      if (por_detect) begin
         nxt_s.src = SRC_POR_VAL;
         nxt_s.ctrl = CTRL_RST;
         nxt_s.powerup = 1'b1;
      end

      // Core reset stretch; the power-up window closes with it
      if (any_rst) begin
         nxt_s.hold_cnt = HOLD_CNT;
      end else if (s_ff.hold_cnt != 8'h00) begin
         nxt_s.hold_cnt = s_ff.hold_cnt - 8'h01;
      end else begin
         nxt_s.powerup = 1'b0;
      end

      // Clock divider: new setting loaded only at a tick boundary
      nxt_s.core_tick = 1'b0;
      if (s_ff.div_cnt == 9'h000) begin
         nxt_s.core_tick = 1'b1;
         nxt_s.div_act = s_ff.div_set;
         nxt_s.div_cnt = rpmc_ratio_m1(s_ff.div_set);
      end else begin
         nxt_s.div_cnt = s_ff.div_cnt - 9'h001;
      end

      // Power mode sequencing
      if (any_rst) begin
         if (s_ff.mode == RPMC_PD || s_ff.mode == RPMC_TPD) begin
            nxt_s.mode = RPMC_WAKE;
            nxt_s.wake_cnt = s_ff.ctrl[CTL_RCSEL] ? WAKE_RC_CNT : WAKE_XTAL_CNT;
         end else if (s_ff.mode == RPMC_IDLE) begin
            nxt_s.mode = RPMC_RUN;
         end
      end else begin
         case (s_ff.mode)
            RPMC_RUN: begin
               if (mode_req == REQ_IDLE) begin
                  nxt_s.mode = RPMC_IDLE;
               end else if (mode_req == REQ_PD) begin
                  nxt_s.mode = RPMC_PD;
               end else if (mode_req == REQ_TPD) begin
                  nxt_s.mode = RPMC_TPD;
               end
            end
            RPMC_IDLE: begin
               if (irq_pending) nxt_s.mode = RPMC_RUN;
            end
            RPMC_PD, RPMC_TPD: begin
               if (wake_irq) begin
                  nxt_s.mode = RPMC_WAKE;
                  nxt_s.wake_cnt = s_ff.ctrl[CTL_RCSEL] ? WAKE_RC_CNT : WAKE_XTAL_CNT;
               end
            end
            RPMC_WAKE: begin
               if (s_ff.wake_cnt == 16'h0000) begin
                  nxt_s.mode = RPMC_RUN;
               end else begin
                  nxt_s.wake_cnt = s_ff.wake_cnt - 16'h0001;
               end
            end
            default: begin
               nxt_s.mode = RPMC_RUN;
            end
         endcase
      end
   end

   // ********************************************************
   // Registers
   // ********************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_ff.ctrl <= CTRL_RST;
         s_ff.src <= SRC_POR_VAL;
         s_ff.div_set <= 8'h00;
         s_ff.div_act <= 8'h00;
         s_ff.div_cnt <= 9'h000;
         s_ff.core_tick <= 1'b0;
         s_ff.mode <= RPMC_RUN;
         s_ff.wake_cnt <= 16'h0000;
         s_ff.hold_cnt <= HOLD_CNT;
         s_ff.powerup <= 1'b1;
         s_ff.brk_cnt <= 4'h0;
         s_ff.brk_armed <= 1'b0;
         s_ff.ack <= 1'b0;
         s_ff.rdat <= 32'h0000_0000;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end

   // ********************************************************
   // Outputs
   // ********************************************************
   assign wb_dat_o = s_ff.rdat;
   assign wb_ack_o = s_ff.ack;
   assign core_rst_n = (s_ff.hold_cnt == 8'h00);
   assign core_clk_en = s_ff.core_tick && (s_ff.mode == RPMC_RUN) && core_rst_n;
   assign periph_clk_en = (s_ff.mode == RPMC_RUN) || (s_ff.mode == RPMC_IDLE);
   assign osc_en = (s_ff.mode != RPMC_PD) && (s_ff.mode != RPMC_TPD);
   assign rc_osc_en = osc_en || (s_ff.ctrl[CTL_RCSEL] && s_ff.ctrl[CTL_RTCEN]);
   assign bod_power_en = s_ff.ctrl[CTL_BO_EN] && (s_ff.mode != RPMC_TPD);
   assign cmp_power_en = !s_ff.ctrl[CTL_CMPPD] && (s_ff.mode != RPMC_TPD);
   assign bo_irq = s_ff.ctrl[CTL_BO_EN] && s_ff.ctrl[CTL_BOIRQ] && bo_level && (s_ff.mode != RPMC_TPD);
   assign pin_gpio_in = (s_ff.ctrl[CTL_PIN_EN] || s_ff.powerup) ? 1'b1 : rst_pin_in;

   // ********************************************************
   // Assertions
   // ********************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_por_flags;
      ce && por_detect |=> s_ff.src == SRC_POR_VAL && !core_rst_n;
   endproperty
   a_por_flags: assert property (p_por_flags) else $error("power-on did not set flags and reset");

   property p_pof_sticky;
      s_ff.src[SRC_PWR_ON] && !src_clr[SRC_PWR_ON] |=> s_ff.src[SRC_PWR_ON];
   endproperty
   a_pof_sticky: assert property (p_pof_sticky) else $error("power-on flag lost without clear");

   property p_bo_reset;
      ce && bo_level && s_ff.ctrl[CTL_BO_EN] && !s_ff.ctrl[CTL_BOIRQ] && s_ff.mode != RPMC_TPD
         |=> !core_rst_n && s_ff.src[SRC_BROWN];
   endproperty
   a_bo_reset: assert property (p_bo_reset) else $error("brownout did not reset");

   property p_bo_irq_mode;
      ce && bo_irq |=> s_ff.src[SRC_BROWN] && $past(s_ff.ctrl[CTL_BOIRQ]);
   endproperty
   a_bo_irq_mode: assert property (p_bo_irq_mode) else $error("brownout interrupt without flag");

   property p_bo_disabled;
      !s_ff.ctrl[CTL_BO_EN] |-> !bo_irq && !bo_rst;
   endproperty
   a_bo_disabled: assert property (p_bo_disabled) else $error("disabled brownout still active");

   property p_pin_powerup;
      ce && !rst_pin_in && s_ff.powerup && !por_detect |=> !core_rst_n && s_ff.src[SRC_EXT];
   endproperty
   a_pin_powerup: assert property (p_pin_powerup) else $error("pin low in power-up did not reset");

   property p_pin_gpio;
      !s_ff.ctrl[CTL_PIN_EN] && !s_ff.powerup |-> !pin_rst && pin_gpio_in == rst_pin_in;
   endproperty
   a_pin_gpio: assert property (p_pin_gpio) else $error("pin acted as reset while disabled");

   property p_pd_osc;
      s_ff.mode == RPMC_PD || s_ff.mode == RPMC_TPD |-> !osc_en && !core_clk_en;
   endproperty
   a_pd_osc: assert property (p_pd_osc) else $error("oscillator running in power-down");

   property p_tpd_off;
      s_ff.mode == RPMC_TPD |-> !bod_power_en && !cmp_power_en && !bo_irq;
   endproperty
   a_tpd_off: assert property (p_tpd_off) else $error("analog blocks on in total power-down");

   property p_idle_exit;
      ce && s_ff.mode == RPMC_IDLE && irq_pending |=> s_ff.mode == RPMC_RUN;
   endproperty
   a_idle_exit: assert property (p_idle_exit) else $error("idle not left on interrupt");

   property p_div_change;
      ce && !s_ff.core_tick && s_ff.div_cnt != 9'h000 |=> s_ff.div_act == $past(s_ff.div_act);
   endproperty
   a_div_change: assert property (p_div_change) else $error("divider changed mid period");

   property p_wake_hold;
      s_ff.mode == RPMC_WAKE |-> osc_en && !core_clk_en;
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("core clock ran during wake delay");

   c_idle_wake: cover property (s_ff.mode == RPMC_IDLE ##1 s_ff.mode == RPMC_RUN);
   c_pd_wake: cover property (s_ff.mode == RPMC_PD ##1 s_ff.mode == RPMC_WAKE);
   c_brk_reset: cover property (brk_rst && ce);
   c_multi_flag: cover property (s_ff.src[SRC_WDT] && s_ff.src[SRC_SW]);

endmodule

`default_nettype wire

// file: sim/rpmc_bench.sv
// Self-checking bench for the reset and power mode controller
`timescale 1ns/1ps
`default_nettype none

module rpmc_bench;
   import rpmc_pkg::*;
   localparam int HOLD = 8;
   localparam int W_RC = 4;
   localparam int W_XT = 8;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [ADR_W-1:0] wb_adr_i = 5'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic [31:0] q;
   logic por_detect = 1'b0;
   logic bo_level = 1'b0;
   logic wdt_reset_req = 1'b0;
   logic irq_pending = 1'b0;
   logic wake_irq = 1'b0;
   logic pin_low = 1'b1;
   logic brk_req = 1'b0;
   logic uart_rx, uart_bit_tick, rst_pin_in, wb_ack_o, core_rst_n, core_clk_en;
   logic periph_clk_en, osc_en, rc_osc_en, bod_power_en, cmp_power_en, bo_irq, pin_gpio_in;
   int err_count = 0;
   int n_compared = 0;

   rpmc_top #(.RST_HOLD(HOLD), .WAKE_RC(W_RC), .WAKE_XTAL(W_XT)) u_rpmc_top (
      .clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .por_detect(por_detect), .bo_level(bo_level),
      .wdt_reset_req(wdt_reset_req), .uart_rx(uart_rx), .uart_bit_tick(uart_bit_tick),
      .rst_pin_in(rst_pin_in), .irq_pending(irq_pending), .wake_irq(wake_irq),
      .core_rst_n(core_rst_n), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
      .osc_en(osc_en), .rc_osc_en(rc_osc_en), .bod_power_en(bod_power_en),
      .cmp_power_en(cmp_power_en), .bo_irq(bo_irq), .pin_gpio_in(pin_gpio_in));

   rpmc_far_model u_rpmc_far_model (.clk(clk), .brk_req(brk_req), .pin_low_req(pin_low),
      .uart_rx(uart_rx), .uart_bit_tick(uart_bit_tick), .rst_pin_in(rst_pin_in));

   // ********************************************************
   // Shared tasks
   // ********************************************************
   task automatic results;
      if (err_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'h3;
      wb_dat_i <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_sel_i <= 4'h0;
      @(posedge clk);
      chk("bus ack latency", n, 2);
      chk("bus ack one cycle", wb_ack_o, 1'b0);
   endtask

   task automatic wait_rst;
      int n;
      n = 0;
      while (core_rst_n !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk("core reset entered", n < 100, 1'b1);
      n = 0;
      while (core_rst_n !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk("core reset left", n < 100, 1'b1);
   endtask

   task automatic gap(output int n);
      int w;
      w = 0;
      do begin
         @(posedge clk);
         w++;
      end while (core_clk_en !== 1'b1 && w < 600);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (core_clk_en !== 1'b1 && n < 600);
   endtask

   // ********************************************************
   // Scenarios
   // ********************************************************
   task automatic t_pin;
      wb(1'b0, ADDR_CTRL, 32'h0, q);
      chk("ctrl reset value", q, 32'h021);
      wb(1'b0, ADDR_STAT, 32'h0, q);
      chk("power-up status", q, 32'h18);
      wb(1'b0, ADDR_SRC, 32'h0, q);
      chk("power-up flags", q & 32'h3E, 32'h06);
      wb(1'b1, ADDR_CTRL, 32'h001, q);
      cyc(20);
      chk("pin holds power-up", core_rst_n, 1'b0);
      chk("pin in reset role", pin_gpio_in, 1'b1);
      pin_low <= 1'b0;
      wait_rst();
      pin_low <= 1'b1;
      cyc(20);
      chk("pin as input no reset", core_rst_n, 1'b1);
      chk("pin input level", pin_gpio_in, 1'b0);
      pin_low <= 1'b0;
      wb(1'b1, ADDR_CTRL, 32'h021, q);
      pin_low <= 1'b1;
      cyc(2);
      pin_low <= 1'b0;
      wait_rst();
      wb(1'b0, ADDR_SRC, 32'h0, q);
      chk("pin flag", q & 32'h01, 32'h01);
      wb(1'b1, ADDR_SRC, 32'h0, q);
      wb(1'b0, ADDR_SRC, 32'h0, q);
      chk("flags cleared", q, 32'h0);
   endtask

   task automatic t_src;
      logic [5:0] m [4];
      logic [5:0] acc;
      m = '{6'h10, 6'h08, 6'h04, 6'h20};
      acc = 6'h00;
      for (int i = 0; i < 4; i++) begin
         case (i)
            0: wb(1'b1, ADDR_CTRL, 32'h025, q);
            1: wdt_reset_req <= 1'b1;
            2: bo_level <= 1'b1;
            default: begin
               wb(1'b1, ADDR_CTRL, 32'h221, q);
               brk_req <= 1'b1;
               cyc(36);
               chk("no early break", core_rst_n, 1'b1);
               brk_req <= 1'b0;
               cyc(8);
               brk_req <= 1'b1;
            end
         endcase
         cyc(2);
         wdt_reset_req <= 1'b0;
         bo_level <= 1'b0;
         wait_rst();
         brk_req <= 1'b0;
         acc = acc | m[i];
         wb(1'b0, ADDR_SRC, 32'h0, q);
         chk("source flags", q, {26'h0, acc});
      end
   endtask

   task automatic t_bo;
      wb(1'b1, ADDR_SRC, 32'h0, q);
      wb(1'b1, ADDR_CTRL, 32'h023, q);
      bo_level <= 1'b1;
      cyc(3);
      chk("brownout irq", bo_irq, 1'b1);
      chk("irq mode no reset", core_rst_n, 1'b1);
      bo_level <= 1'b0;
      wb(1'b0, ADDR_SRC, 32'h0, q);
      chk("irq mode flag", q, 32'h04);
      wb(1'b1, ADDR_SRC, 32'h0, q);
      wb(1'b1, ADDR_CTRL, 32'h022, q);
      bo_level <= 1'b1;
      cyc(3);
      chk("disabled irq", bo_irq, 1'b0);
      chk("disabled reset", core_rst_n, 1'b1);
      bo_level <= 1'b0;
      wb(1'b0, ADDR_SRC, 32'h0, q);
      chk("disabled flag", q, 32'h0);
      wb(1'b1, ADDR_CTRL, 32'h021, q);
      ce <= 1'b0;
      bo_level <= 1'b1;
      cyc(4);
      chk("frozen no reset", core_rst_n, 1'b1);
      bo_level <= 1'b0;
      ce <= 1'b1;
      cyc(1);
      wb(1'b0, ADDR_SRC, 32'h0, q);
      chk("frozen no flag", q, 32'h0);
   endtask

   task automatic t_modes;
      logic [9:0] c [3];
      logic [2:0] e [3];
      int n;
      int w;
      c = '{10'h0F1, 10'h031, 10'h039};
      e = '{3'b111, 3'b011, 3'b000};
      wb(1'b1, ADDR_CTRL, 32'h121, q);
      chk("comparator off alone", cmp_power_en, 1'b0);
      wb(1'b1, ADDR_CTRL, 32'h029, q);
      wb(1'b0, ADDR_STAT, 32'h0, q);
      chk("idle mode", q[2:0], 3'h1);
      chk("idle core clock", core_clk_en, 1'b0);
      chk("idle peripherals", periph_clk_en, 1'b1);
      irq_pending <= 1'b1;
      cyc(2);
      irq_pending <= 1'b0;
      cyc(1);
      chk("idle ends on irq", core_clk_en, 1'b1);
      for (int k = 0; k < 3; k++) begin
         wb(1'b1, ADDR_CTRL, {22'h0, c[k]}, q);
         cyc(2);
         chk("oscillator stopped", osc_en, 1'b0);
         chk("core clock stopped", core_clk_en, 1'b0);
         chk("rc oscillator", rc_osc_en, e[k][2]);
         chk("brownout power", bod_power_en, e[k][1]);
         chk("comparator power", cmp_power_en, e[k][0]);
         if (k == 2) begin
            wdt_reset_req <= 1'b1;
            cyc(2);
            wdt_reset_req <= 1'b0;
            wait_rst();
            cyc(W_XT + 4);
         end else begin
            w = (k == 0) ? W_RC : W_XT;
            wake_irq <= 1'b1;
            @(posedge clk);
            wake_irq <= 1'b0;
            n = 0;
            do begin
               @(posedge clk);
               n++;
            end while (core_clk_en !== 1'b1 && n < 2000);
            chk("wake delay", n >= w && n <= w + 3, 1'b1);
         end
         wb(1'b0, ADDR_STAT, 32'h0, q);
         chk("back to run", q[2:0], 3'h0);
      end
   endtask

   task automatic t_div;
      logic [7:0] v [3];
      int p [3];
      int n;
      v = '{8'h00, 8'h02, 8'hFF};
      p = '{1, 4, 510};
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, ADDR_DIV, {24'h0, v[i]}, q);
         gap(n);
         gap(n);
         chk("core clock period", n, p[i]);
         chk("running through change", core_rst_n, 1'b1);
      end
      wb(1'b0, ADDR_DIV, 32'h0, q);
      chk("divider readback", q, 32'hFF);
      wb(1'b0, 5'h10, 32'h0, q);
      chk("unmapped read", q, 32'h0);
      wb(1'b1, ADDR_DIV, 32'h0, q);
   endtask

   task automatic t_por;
      wb(1'b1, ADDR_CTRL, 32'h0C0, q);
      por_detect <= 1'b1;
      cyc(2);
      por_detect <= 1'b0;
      wait_rst();
      wb(1'b0, ADDR_CTRL, 32'h0, q);
      chk("ctrl after power-on", q, 32'h021);
      wb(1'b0, ADDR_SRC, 32'h0, q);
      chk("flags after power-on", q, 32'h06);
   endtask

   initial begin
      forever #2.5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      results();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_pin();
      t_src();
      t_bo();
      t_modes();
      t_div();
      t_por();
      results();
   end
endmodule

`default_nettype wire

// file: sim/rpmc_far_model.sv
// Far-side model: UART receive line with bit ticks and the shared reset pin
`timescale 1ns/1ps
`default_nettype none

module rpmc_far_model (
   input wire logic clk,
   input wire logic brk_req,
   input wire logic pin_low_req,
   output logic uart_rx,
   output logic uart_bit_tick,
   output logic rst_pin_in
);
   logic [1:0] div_ff = 2'h0;

   // ********************************************************
   // Bit time of four clocks, line idles high
   // ********************************************************
   always_ff @(posedge clk) begin
      div_ff <= div_ff + 2'h1;
   end
   assign uart_bit_tick = (div_ff == 2'h3);
   assign uart_rx = !brk_req;
   // Pin has a pull-up, so a released pin reads high
   assign rst_pin_in = !pin_low_req;
endmodule

`default_nettype wire
